// ### inc/serial_flash_pkg.sv
// serial flash front end: opcodes, phases and carriers shared by all files but the synchroniser
// assumes one compilation of this package ahead of the hw/ modules
package serial_flash_pkg;
    // instruction codes that the front end acts on
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_FAST      = 8'h0b;
    localparam logic [7:0] OP_DUAL_OUT  = 8'h3b;
    localparam logic [7:0] OP_DUAL_IO   = 8'hbb;
    localparam logic [7:0] OP_QUAD_OUT  = 8'h6b;
    localparam logic [7:0] OP_QUAD_IO   = 8'heb;
    localparam logic [7:0] OP_PROG      = 8'h02;
    localparam logic [7:0] OP_QPROG     = 8'h32;
    localparam logic [7:0] OP_QPROG_ALT = 8'h38;
    localparam logic [7:0] OP_DTR       = 8'h0d;
    localparam logic [7:0] OP_DTR_DUAL  = 8'hbd;
    localparam logic [7:0] OP_DTR_QUAD  = 8'hed;
    localparam logic [7:0] OP_ENTER_QI  = 8'h35;
    localparam logic [7:0] OP_EXIT_QI   = 8'hf5;
    localparam logic [7:0] OP_RST_EN    = 8'h66;
    localparam logic [7:0] OP_RST       = 8'h99;
    // bit counts of each transfer phase
    localparam logic [4:0] OPCODE_BITS  = 5'h08;
    localparam logic [4:0] ADDR_BITS    = 5'h18;
    localparam logic [4:0] DATA_BITS    = 5'h08;
    localparam logic [4:0] DUMMY_CLKS   = 5'h08;
    // unprogrammed cells read as all ones
    localparam logic [7:0] ERASED_BYTE  = 8'hff;
    // lanes per edge and the matching output enables
    localparam logic [2:0] LANE1        = 3'h1;
    localparam logic [2:0] LANE2        = 3'h2;
    localparam logic [2:0] LANE4        = 3'h4;
    localparam logic [3:0] OE_SINGLE    = 4'h2;
    localparam logic [3:0] OE_DUAL      = 4'h3;
    localparam logic [3:0] OE_QUAD      = 4'hf;

    typedef enum logic [2:0] {
        PH_OP, PH_ADDR, PH_DUMMY, PH_RX, PH_TX, PH_IDLE
    } phase_type;

    typedef enum logic [1:0] {CK_OTHER, CK_READ, CK_PROG} kind_type;

    typedef struct packed {
        kind_type   kind;   // read, program or neither
        logic [2:0] addrW;  // address lanes
        logic [2:0] dataW;  // data lanes
        logic       dtr;    // both-edge address and data
        logic       dummy;  // dummy clocks before data
    } cmd_type;

    typedef struct packed {
        logic [3:0] out;    // data lines 3..0
        logic [3:0] oe;     // high while driven
    } pinDrive_type;

    typedef struct packed {
        logic       strobe; // one cycle per opcode
        logic [7:0] code;   // last opcode taken
    } opReport_type;
endpackage

// ### hw/sync_two_stage.sv
// two flip-flop synchroniser for levels, width set by parameter
// assumes each bit is a level or a toggle, never a multi-bit word
`timescale 1ns/100ps
module sync_two_stage #(
    parameter int W = 1     // bits synchronised
) (
    input  wire logic         clk,  // destination clock
    input  wire logic         rstN, // async reset, low
    input  wire logic [W-1:0] d,    // level from other domain
    output logic      [W-1:0] q     // synchronised level
);
    logic [1:0][W-1:0] stFf;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            stFf <= '0;
        end else begin
            stFf <= {stFf[0], d};
        end
    end

    assign q = stFf[1];
endmodule // sync_two_stage

// ### hw/flash_cell_array.sv
// small byte array standing in for the flash cells
// assumes one write and one combinational read per link clock edge
`timescale 1ns/100ps
module flash_cell_array
    import serial_flash_pkg::*;
#(
    parameter int DEPTH = 256               // bytes held
) (
    input  wire logic                     clk,   // link clock
    input  wire logic                     rstN,  // async reset, low
    input  wire logic                     we,    // program strobe
    input  wire logic [$clog2(DEPTH)-1:0] wAddr, // program index
    input  wire logic [7:0]               wData, // program byte
    input  wire logic [$clog2(DEPTH)-1:0] rAddr, // read index
    output logic      [7:0]               rData  // read byte
);
    logic [7:0]       cells [DEPTH];
    logic [DEPTH-1:0] writtenFf;
    logic             anyWrFf;
    logic [7:0]       oldByte;

    // cells have no reset; a written mask stands in for the erased state
    assign oldByte = writtenFf[wAddr] ? cells[wAddr] : ERASED_BYTE;
    assign rData   = writtenFf[rAddr] ? cells[rAddr] : ERASED_BYTE;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            writtenFf <= '0;
            anyWrFf   <= 1'b0;
        end else if (we) begin
            writtenFf[wAddr] <= 1'b1;
            anyWrFf          <= 1'b1;
        end
    end

    // programming only clears bits, as a flash cell does
    always_ff @(posedge clk) begin
        if (we) begin
            cells[wAddr] <= oldByte & wData;
        end
    end

    a_erased_read: assert property (
        @(posedge clk) disable iff (!rstN)
        !anyWrFf |-> rData == ERASED_BYTE)
        else $error("unprogrammed array not read as erased");
endmodule // flash_cell_array

// ### hw/serial_flash_front.sv
// serial flash front end: link shift logic, mode tracking, data lanes
// assumes the master frames each instruction with csN and stops sck
// outside frames; link logic runs on sck, reporting on clk_sys
`timescale 1ns/100ps
module serial_flash_front
    import serial_flash_pkg::*;
#(
    parameter int         MEM_DEPTH = 256,       // bytes held
    parameter logic [4:0] DUMMY     = DUMMY_CLKS // dummy clocks
) (
    input  wire logic         clk_sys,       // system clock
    input  wire logic         nrst,          // async reset, low
    input  wire logic         sck,           // link clock, master
    input  wire logic         csN,           // frame select, low
    input  wire logic [3:0]   dqIn,          // data lines 3..0 in
    output pinDrive_type      dqDrive,       // data lines out, oe
    output logic              modeQuadInstr, // quad instruction mode
    output opReport_type      opReport,      // opcode strobe, code
    output logic              frameActive    // select low, synced
);
    localparam int AW = $clog2(MEM_DEPTH);

    // refuse depths that the index logic cannot serve
    if (MEM_DEPTH < 32'h2 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("MEM_DEPTH must be a power of two, at least 2");
    end
    if (DUMMY == 5'h00) begin : g_bad_dummy
        $error("DUMMY must be at least one clock");
    end

    typedef struct packed {
        phase_type    phase;
        logic [4:0]   cnt;
        logic [23:0]  sh;
        logic [7:0]   op;
        cmd_type      cmd;
        logic [23:0]  addr;
        logic [7:0]   tx;
        logic [3:0]   riseOut;
        logic         qi;
        logic         rstArm;
        logic         evTog;
    } linkState_type;

    typedef struct packed {
        pinDrive_type drv;
        logic [3:0]   smp;
    } fallState_type;

    typedef struct packed {
        logic         tog;
        logic         qi;
        logic         act;
        opReport_type rep;
    } sysState_type;

    logic          rstN;
    linkState_type linkFf, nxtLink;
    fallState_type fallFf, nxtFall;
    sysState_type  sysFf, nxtSys;
    logic          freshFf;
    logic [4:0]    riseCntFf;
    logic [4:0]    riseNow;
    logic [2:0]    syncQ;
    logic          memWe;
    logic [AW-1:0] memWAddr;
    logic [AW-1:0] memRAddr;
    logic [7:0]    memWData;
    logic [7:0]    memRData;
    logic          opDone;
    logic [7:0]    opNow;
    logic [2:0]    lanes;
    logic [4:0]    step;
    logic          dtrAddr;

    // command table: lanes for address and data, dummy and double rate
    function automatic cmd_type decode(input logic [7:0] op,
                                       input logic       qi);
        cmd_type c;
        c = '{CK_OTHER, LANE1, LANE1, 1'b0, 1'b0};
        case (op)
            OP_READ:      c = '{CK_READ, LANE1, LANE1, 1'b0, 1'b0};
            OP_FAST:      c = '{CK_READ, LANE1, LANE1, 1'b0, 1'b1};
            OP_DUAL_OUT:  c = '{CK_READ, LANE1, LANE2, 1'b0, 1'b1};
            OP_DUAL_IO:   c = '{CK_READ, LANE2, LANE2, 1'b0, 1'b1};
            OP_QUAD_OUT:  c = '{CK_READ, LANE1, LANE4, 1'b0, 1'b1};
            OP_QUAD_IO:   c = '{CK_READ, LANE4, LANE4, 1'b0, 1'b1};
            OP_DTR:       c = '{CK_READ, LANE1, LANE1, 1'b1, 1'b1};
            OP_DTR_DUAL:  c = '{CK_READ, LANE2, LANE2, 1'b1, 1'b1};
            OP_DTR_QUAD:  c = '{CK_READ, LANE4, LANE4, 1'b1, 1'b1};
            OP_PROG:      c = '{CK_PROG, LANE1, LANE1, 1'b0, 1'b0};
            OP_QPROG:     c = '{CK_PROG, LANE1, LANE4, 1'b0, 1'b0};
            OP_QPROG_ALT: c = '{CK_PROG, LANE1, LANE4, 1'b0, 1'b0};
            default:      c = '{CK_OTHER, LANE1, LANE1, 1'b0, 1'b0};
        endcase
        // quad instruction mode moves every phase over four lines
        if (qi) begin
            c.addrW = LANE4;
            c.dataW = LANE4;
        end
        return c;
    endfunction

    // shift one edge worth of lines into the low end
    function automatic logic [23:0] shin(input logic [23:0] s,
                                         input logic [2:0]  w,
                                         input logic [3:0]  d);
        case (w)
            LANE2:   return {s[21:0], d[1:0]};
            LANE4:   return {s[19:0], d};
            default: return {s[22:0], d[0]};
        endcase
    endfunction

    // top bits of a byte placed on the lines of the given width
    function automatic pinDrive_type laneDrive(input logic [7:0] b,
                                               input logic [2:0] w);
        case (w)
            LANE2:   return '{{2'b00, b[7:6]}, OE_DUAL};
            LANE4:   return '{b[7:4], OE_QUAD};
            default: return '{{2'b00, b[7], 1'b0}, OE_SINGLE};
        endcase
    endfunction

    // reset release through two flops; everything else uses rstN
    sync_two_stage #(.W(1)) u_rst_sync (
        .clk  (clk_sys),
        .rstN (nrst),
        .d    (1'b1),
        .q    (rstN)
    );

    // fresh marks the first rise of a frame; select high sets it
    always_ff @(posedge sck or posedge csN or negedge rstN) begin
        if (!rstN) begin
            freshFf <= 1'b1;
        end else if (csN) begin
            freshFf <= 1'b1;
        end else begin
            freshFf <= 1'b0;
        end
    end

    // rise side: instruction, address and write data come in here
    always_comb begin
        linkState_type cur;
        pinDrive_type  drvTmp;
        cur    = linkFf;
        drvTmp = '0;
        // a new frame drops any part of an old instruction
        if (freshFf) begin
            cur.phase = PH_OP;
            cur.cnt   = '0;
            cur.sh    = '0;
        end
        nxtLink  = cur;
        memWe    = 1'b0;
        memWAddr = cur.addr[AW-1:0];
        memRAddr = cur.addr[AW-1:0];
        opDone   = 1'b0;
        opNow    = 8'h00;
        case (cur.phase)
            PH_OP:   lanes = cur.qi ? LANE4 : LANE1;
            PH_ADDR: lanes = cur.cmd.addrW;
            PH_RX:   lanes = cur.cmd.dataW;
            PH_TX:   lanes = cur.cmd.dataW;
            default: lanes = LANE1;
        endcase
        dtrAddr = cur.cmd.dtr && cur.phase == PH_ADDR;
        if (cur.cmd.dtr && (cur.phase == PH_ADDR || cur.phase == PH_TX))
        begin
            step = 5'({lanes, 1'b0});
        end else begin
            step = 5'(lanes);
        end
        nxtLink.cnt = cur.cnt + step;
        // double rate takes the falling sample first, then the rising
        if (dtrAddr) begin
            nxtLink.sh = shin(shin(cur.sh, lanes, fallFf.smp),
                              lanes, dqIn);
        end else begin
            nxtLink.sh = shin(cur.sh, lanes, dqIn);
        end
        memWData = nxtLink.sh[7:0]; // byte with this rise's unit in it
        case (cur.phase)
            PH_OP: begin
                if (nxtLink.cnt == OPCODE_BITS) begin
                    opDone          = 1'b1;
                    opNow           = nxtLink.sh[7:0];
                    nxtLink.op      = opNow;
                    nxtLink.evTog   = ~cur.evTog;
                    nxtLink.cmd     = decode(opNow, cur.qi);
                    nxtLink.cnt     = '0;
                    nxtLink.sh      = '0;
                    nxtLink.rstArm  = opNow == OP_RST_EN;
                    if (nxtLink.cmd.kind == CK_OTHER) begin
                        nxtLink.phase = PH_IDLE;
                    end else begin
                        nxtLink.phase = PH_ADDR;
                    end
                    // one mode flag, so the two modes never overlap
                    if (opNow == OP_ENTER_QI) begin
                        nxtLink.qi = 1'b1;
                    end
                    if (opNow == OP_EXIT_QI) begin
                        nxtLink.qi = 1'b0;
                    end
                    if (opNow == OP_RST && cur.rstArm) begin
                        nxtLink.qi = 1'b0;
                    end
                end
            end
            PH_ADDR: begin
                if (nxtLink.cnt == ADDR_BITS) begin
                    nxtLink.addr = nxtLink.sh;
                    nxtLink.cnt  = '0;
                    memRAddr     = nxtLink.sh[AW-1:0];
                    if (cur.cmd.kind == CK_PROG) begin
                        nxtLink.phase = PH_RX;
                    end else if (cur.cmd.dummy) begin
                        nxtLink.phase = PH_DUMMY;
                    end else begin
                        nxtLink.phase = PH_TX;
                        nxtLink.tx    = memRData;
                    end
                end
            end
            PH_DUMMY: begin
                if (nxtLink.cnt == DUMMY) begin
                    nxtLink.phase = PH_TX;
                    nxtLink.cnt   = '0;
                    nxtLink.tx    = memRData;
                end
            end
            PH_TX: begin
                // fall drives the top unit; in double rate the rise
                // drives the next one before the byte moves on
                drvTmp          = laneDrive(8'(cur.tx << lanes), lanes);
                nxtLink.riseOut = drvTmp.out;
                nxtLink.tx      = 8'(cur.tx << step);
                if (nxtLink.cnt == DATA_BITS) begin
                    nxtLink.cnt  = '0;
                    nxtLink.addr = cur.addr + 24'h000001;
                    memRAddr     = nxtLink.addr[AW-1:0];
                    nxtLink.tx   = memRData;
                end
            end
            PH_RX: begin
                if (nxtLink.cnt == DATA_BITS) begin
                    memWe        = 1'b1;
                    nxtLink.cnt  = '0;
                    nxtLink.addr = cur.addr + 24'h000001;
                end
            end
            default: begin
                nxtLink.cnt = cur.cnt;
            end
        endcase
    end

    // mode and arm flags change only by opcode or power reset, not per frame
    always_ff @(posedge sck or negedge rstN) begin
        if (!rstN) begin
            linkFf <= '0;
        end else begin
            linkFf <= nxtLink;
        end
    end

    // fall side: drive read data, keep a sample for double rate;
    // the fresh guard stops a mode 1,1 leading fall driving stale data
    always_comb begin
        nxtFall.smp = dqIn;
        nxtFall.drv = '0;
        if (!freshFf && linkFf.phase == PH_TX) begin
            nxtFall.drv = laneDrive(linkFf.tx,
                                    linkFf.cmd.dataW);
        end
    end

    always_ff @(negedge sck or posedge csN or negedge rstN) begin
        if (!rstN) begin
            fallFf <= '0;
        end else if (csN) begin
            fallFf <= '0;
        end else begin
            fallFf <= nxtFall;
        end
    end

    // line order 0..3 is input, output, protect, hold in single line mode;
    // sck picks the rise copy only in double rate, where data
    // changes on both edges
    assign dqDrive = '{
        out: (linkFf.cmd.dtr && sck) ? linkFf.riseOut : fallFf.drv.out,
        oe:  fallFf.drv.oe
    };

    // mode, opcode toggle and select level into the system domain
    sync_two_stage #(.W(3)) u_link_sync (
        .clk  (clk_sys),
        .rstN (rstN),
        .d    ({linkFf.qi, linkFf.evTog, ~csN}),
        .q    (syncQ)
    );

    // the opcode byte holds for a whole instruction after its toggle,
    // far longer than the three system cycles needed to take it
    always_comb begin
        nxtSys            = sysFf;
        nxtSys.qi         = syncQ[2];
        nxtSys.tog        = syncQ[1];
        nxtSys.act        = syncQ[0];
        nxtSys.rep.strobe = syncQ[1] != sysFf.tog;
        if (syncQ[1] != sysFf.tog) begin
            nxtSys.rep.code = linkFf.op;
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            sysFf <= '0;
        end else begin
            sysFf <= nxtSys;
        end
    end

    assign modeQuadInstr = sysFf.qi;
    assign opReport      = sysFf.rep;
    assign frameActive   = sysFf.act;

    flash_cell_array #(.DEPTH(MEM_DEPTH)) u_cells (
        .clk   (sck),
        .rstN  (rstN),
        .we    (memWe),
        .wAddr (memWAddr),
        .wData (memWData),
        .rAddr (memRAddr),
        .rData (memRData)
    );

    // rises seen in the current frame, for the checks below
    always_ff @(posedge sck or negedge rstN) begin
        if (!rstN) begin
            riseCntFf <= 5'h00;
        end else if (freshFf) begin
            riseCntFf <= 5'h01;
        end else if (riseCntFf != 5'h1f) begin
            riseCntFf <= riseCntFf + 5'h01;
        end
    end
    assign riseNow = freshFf ? 5'h00 : riseCntFf;

    sequence s_op_end(logic [7:0] code);
        opDone && opNow == code;
    endsequence

    a_single_sample: assert property (
        @(posedge sck) disable iff (csN || !rstN)
        (!freshFf && linkFf.phase == PH_OP && !linkFf.qi &&
         linkFf.cnt < 5'h07) |=> linkFf.sh[0] == $past(dqIn[0]))
        else $error("single line opcode bit not sampled");

    a_opcode_eight: assert property (
        @(posedge sck) disable iff (csN || !rstN)
        (opDone && !linkFf.qi) |-> riseNow == 5'h07)
        else $error("single line opcode not eight clocks");

    a_opcode_two: assert property (
        @(posedge sck) disable iff (csN || !rstN)
        (opDone && linkFf.qi) |-> riseNow == 5'h01)
        else $error("quad instruction opcode not two clocks");

    a_enter_quad: assert property (
        @(posedge sck) disable iff (csN || !rstN)
        s_op_end(OP_ENTER_QI) |=> linkFf.qi)
        else $error("enter opcode did not set the mode");

    a_exit_quad: assert property (
        @(posedge sck) disable iff (csN || !rstN)
        s_op_end(OP_EXIT_QI) |=> !linkFf.qi)
        else $error("exit opcode did not clear the mode");

    a_mode_steady: assert property (
        @(posedge sck) disable iff (csN || !rstN)
        !opDone |=> $stable(linkFf.qi))
        else $error("mode changed without an opcode");

    a_soft_reset: assert property (
        @(posedge sck) disable iff (csN || !rstN)
        (s_op_end(OP_RST) ##0 linkFf.rstArm) |=> !linkFf.qi)
        else $error("software reset left quad instruction mode");

    a_frame_restart: assert property (
        @(posedge sck) disable iff (csN || !rstN)
        (freshFf && !linkFf.qi) |=>
            (linkFf.phase == PH_OP && linkFf.cnt == 5'h01))
        else $error("new frame did not restart the opcode");

    a_dtr_addr: assert property (
        @(posedge sck) disable iff (csN || !rstN)
        (!freshFf && dtrAddr && nxtLink.phase == PH_ADDR) |=>
            linkFf.cnt == 5'($past(linkFf.cnt) +
                             {$past(linkFf.cmd.addrW), 1'b0}))
        else $error("double rate address not two units a clock");

    a_single_out: assert property (
        @(negedge sck) disable iff (csN || !rstN)
        (fallFf.drv.oe != 4'h0 && linkFf.cmd.dataW == LANE1) |->
            fallFf.drv.oe == OE_SINGLE)
        else $error("single line data not on output line only");

    a_quad_lines: assert property (
        @(negedge sck) disable iff (csN || !rstN)
        (fallFf.drv.oe != 4'h0 && linkFf.qi) |-> fallFf.drv.oe == OE_QUAD)
        else $error("quad instruction data not on four lines");

    a_report_pulse: assert property (
        @(posedge clk_sys) disable iff (!rstN)
        opReport.strobe |=> !opReport.strobe)
        else $error("opcode strobe longer than one cycle");
endmodule // serial_flash_front

// ### tb/flash_master_model.sv
// host side link master: frames, shifts lanes, samples device output
// assumes link mode 0, sck still outside frames, device drives on falls
`timescale 1ns/100ps
module flash_master_model
    import serial_flash_pkg::*;
(
    output logic         sck,    // link clock, idle low
    output logic         csN,    // frame select, low
    output logic [3:0]   dqIn,   // resolved data lines
    input  pinDrive_type dqDrive // device drive and enables
);
    logic [3:0] mst; // master levels
    logic [3:0] mOe; // master enables
    initial begin
        sck = 0;
        csN = 1;
        mst = 4'h5;
        mOe = 4'h0;
    end
    // released lines show inverted last level, never a stale copy
    always_comb begin
        for (int i = 0; i < 4; i++)
            dqIn[i] = dqDrive.oe[i] ? dqDrive.out[i]
                    : (mOe[i] ? mst[i] : ~mst[i]);
    end
    task automatic frameOpen();
        #20 csN = 0;
        #60;
    endtask
    task automatic frameClose();
        #60 csN = 1;
        mOe = 4'h0;
        #200;
    endtask
    // n units msb first, one or four lanes, set while sck low
    task automatic put(input logic [31:0] v, input int n, input int w);
        mOe = (w == 4) ? 4'hf : 4'h1;
        for (int k = n - 1; k >= 0; k--) begin
            mst = (w == 4) ? v[4*k+:4] : {3'h0, v[k]};
            #80 sck = 1;
            #80 sck = 0;
        end
    endtask
    // read byte msb first: a bit on line 1, or a nibble on lines 3..0
    task automatic get(output logic [7:0] b, input int w);
        mOe = 4'h0;
        for (int k = 8 / w - 1; k >= 0; k--) begin
            #80 b = (w == 4) ? {b[3:0], dqIn} : {b[6:0], dqIn[1]};
            sck = 1;
            #80 sck = 0;
        end
    endtask
endmodule // flash_master_model

// ### tb/tb_top.sv
// self-checking bench for the flash front end with a reference array
// assumes the master model drives the link and mode 0 timing
`timescale 1ns/100ps
module tb_top;
    import serial_flash_pkg::*;
    logic         clk_sys, nrst, sck, csN, modeQuadInstr, frameActive;
    logic [3:0]   dqIn;
    pinDrive_type dqDrive;
    opReport_type opReport;
    int           error_cnt, n_checks, cyc, nStrobe, expOps;
    int           refMem [16];
    logic [31:0]  seed;
    logic [7:0]   b;
    serial_flash_front #(.MEM_DEPTH(16)) dut_u (.clk_sys(clk_sys),
        .nrst(nrst), .sck(sck), .csN(csN), .dqIn(dqIn),
        .dqDrive(dqDrive), .modeQuadInstr(modeQuadInstr),
        .opReport(opReport), .frameActive(frameActive));
    flash_master_model mst_u (.sck(sck), .csN(csN), .dqIn(dqIn),
        .dqDrive(dqDrive));
    initial begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // open a frame and send the opcode units; count whole opcodes for the strobe check
    task automatic cmd(input logic [7:0] op, input int n, input int w);
        if (n * w == 8) expOps++;
        mst_u.frameOpen();
        mst_u.put({24'h0, op}, n, w);
    endtask
    task automatic endCmd();
        mst_u.frameClose();
        repeat (4) @(negedge clk_sys);
    endtask
    // hang guard, ample for the frames below
    always @(posedge clk_sys) begin
        cyc++;
        if (opReport.strobe === 1'b1) nStrobe++;
        if (cyc == 40000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        nrst = 0;
        seed = 32'h2bcfc5d1;
        foreach (refMem[i]) refMem[i] = 255;
        repeat (5) @(negedge clk_sys);
        nrst = 1;
        repeat (4) @(negedge clk_sys);
        check("mode", {7'h0, modeQuadInstr}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            cmd(OP_READ, 8, 1);
            @(negedge clk_sys);
            check("active", {7'h0, frameActive}, 8'h01);
            mst_u.put(seed[23:0], 24, 1);
            mst_u.get(b, 1);
            endCmd();
            check("active", {7'h0, frameActive}, 8'h00);
            check("rdata", b, 8'(refMem[seed[3:0]]));
            check("opcode", opReport.code, OP_READ);
            cmd(OP_PROG, 8, 1);
            mst_u.put(seed[23:0], 24, 1);
            mst_u.put(seed[31:24], 8, 1);
            endCmd();
            refMem[seed[3:0]] &= seed[31:24];
            cmd(OP_READ, 8, 1);
            mst_u.put(seed[23:0], 24, 1);
            mst_u.get(b, 1);
            endCmd();
            check("rback", b, 8'(refMem[seed[3:0]]));
        end
        // quad output read of the last programmed byte, two falls a byte
        cmd(OP_QUAD_OUT, 8, 1);
        mst_u.put(seed[23:0], 24, 1);
        mst_u.put(32'h0, int'(DUMMY_CLKS), 1);
        mst_u.get(b, 4);
        endCmd();
        check("qread", b, 8'(refMem[seed[3:0]]));
        cmd(8'h03, 4, 1); // upper nibble of enter opcode, cut short
        endCmd();
        cmd(8'h55, 8, 1); // would complete 35h if the cut part stayed
        endCmd();
        check("mode", {7'h0, modeQuadInstr}, 8'h00);
        for (int j = 0; j < 2; j++) begin
            cmd(OP_ENTER_QI, 8, 1);
            endCmd();
            check("mode", {7'h0, modeQuadInstr}, 8'h01);
            cmd(j ? OP_RST_EN : OP_EXIT_QI, 2, 4);
            if (j) begin
                endCmd();
                cmd(OP_RST, 2, 4); // enable came in the frame before
            end
            endCmd();
            check("mode", {7'h0, modeQuadInstr}, 8'h00);
        end
        check("opcode", opReport.code, OP_RST);
        check("strobes", 8'(nStrobe), 8'(expOps));
        print_verdict();
    end
endmodule // tb_top
